// >>> shared/conv_seq_pkg.sv
package conv_seq_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
    localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_CLOCK_CTRL = 8'h14;
    // converter_control_0 fields
    localparam int BIT_START_CONV = 0;
    localparam int BIT_CONV_ENABLE = 1;
    localparam int BIT_POWER_ON = 4;
    localparam int BIT_SAMPLE_SEL = 7;
    localparam int POS_SAMPLE_CLKS = 8;
    // converter_control_1 fields
    localparam int POS_SEQ_MODE = 0;
    localparam int BIT_PULSE_MODE = 2;
    localparam int POS_CLK_DIV = 4;
    localparam int POS_CLK_SRC = 8;
    localparam int POS_REF_SEL = 12;
    // status / irq fields
    localparam int BIT_BUSY = 0;
    localparam int BIT_HALTED = 1;
    localparam int BIT_HUNG = 2;
    localparam int BIT_BAD_RESULT = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_SEQ_END = 1;
    localparam int IRQ_TIMER_OVF = 2;
    localparam int IRQ_HALT = 3;
    localparam int IRQ_W = 4;
    // clock system control
    localparam int BIT_SUBSYS_OFF = 0;
    // encodings and counts
    localparam logic [1:0] CLK_SRC_SUBSYS = 2'h3;
    localparam logic [3:0] SAMPLE_MIN_CLKS = 4'h6;
    localparam logic [31:0] CTL0_RESET = 32'h0000_0400;
    localparam logic [31:0] CTL1_RESET = 32'h0000_0004;
    localparam logic [5:0] CONV_CLKS = 6'h0D;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SEQ_SINGLE = 2'b00,
        SEQ_SEQUENCE = 2'b01,
        SEQ_REPEAT_SINGLE = 2'b10,
        SEQ_REPEAT_SEQUENCE = 2'b11
    } seq_mode_t;

    typedef struct packed {
        logic [1:0] clk_src;
        logic [2:0] clk_div;
        logic subsys_off;
    } clk_cfg_t;
endpackage : conv_seq_pkg

// >>> hw/conv_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
// divides aclk into converter clock ticks; freezes when hung
module conv_clock_divider
    import conv_seq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire clk_cfg_t cfg,
    output logic tick,
    output logic hung
);
    logic [2:0] count_r;
    logic [1:0] src_prev_r;
    logic hung_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= 3'h0;
        end else if (hung_r || count_r >= cfg.clk_div) begin
            count_r <= 3'h0;
        end else begin
            count_r <= count_r + 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_prev_r <= CLK_SRC_SUBSYS;
        end else begin
            src_prev_r <= cfg.clk_src;
        end
    end

    // leaving the subsystem clock with off-request set and odd ratio hangs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hung_r <= 1'b0;
        end else if (src_prev_r == CLK_SRC_SUBSYS && cfg.clk_src != CLK_SRC_SUBSYS
                     && cfg.subsys_off && !cfg.clk_div[0] && cfg.clk_div != 3'h0) begin
            hung_r <= 1'b1;
        end
    end

    assign tick = !hung_r && count_r >= cfg.clk_div;
    assign hung = hung_r;
endmodule : conv_clock_divider
`default_nettype wire

// >>> hw/adc_conversion_sequencer.sv
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - a timer trigger at a sequence or single-conversion end without an enable toggle halts.
// - a trigger during busy in sequence or repeat modes halts later conversions.
// - the timer-overflow flag stays clear when such an overlap halts the converter.
// - in sequence-mode 1 or 3 a DMA trigger follows every single conversion.
// - extended sampling, an unbuffered reference and under 6 clocks mark the result bad.
// - toggling power during busy in sequence or repeat modes halts later conversions.
// - leaving the subsystem clock with off-request set and an odd divide ratio of 3, 5 or 7 hangs the converter.
module adc_conversion_sequencer
    import conv_seq_pkg::*;
#(
    parameter int CHANNELS = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timer_trigger,
    output logic dma_trigger,
    output logic [1:0] conv_channel,
    output logic irq
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10,
        ST_HALTED = 2'b11
    } state_t;

    logic [31:0] ctl0_r;
    logic [31:0] ctl1_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic subsys_off_r;
    state_t state_r;
    logic [5:0] cnt_r;
    logic [1:0] chan_r;
    logic busy_r;
    logic armed_r;
    logic bad_r;
    logic dma_r;
    logic power_prev_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    logic tick;
    logic hung;
    logic wr_fire;
    logic ar_fire;
    logic start_req;
    logic overlap;
    logic power_toggle;
    logic conv_done;
    logic last_chan;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    seq_mode_t mode;
    clk_cfg_t clk_cfg;

    assign mode = seq_mode_t'(ctl1_r[POS_SEQ_MODE +: 2]);
    assign clk_cfg.clk_src = ctl1_r[POS_CLK_SRC +: 2];
    assign clk_cfg.clk_div = ctl1_r[POS_CLK_DIV +: 3];
    assign clk_cfg.subsys_off = subsys_off_r;

    conv_clock_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(clk_cfg),
        .tick(tick),
        .hung(hung)
    );

    // axi4-lite write: address and data taken in either order
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign wr_fire = (aw_hold_r || s_axi_awvalid) && (w_hold_r || s_axi_wvalid) && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    logic [7:0] wa;
    logic [31:0] wd;
    logic [31:0] wmask;
    assign wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
    assign wd = w_hold_r ? wdata_r : s_axi_wdata;
    assign wmask = {{8{w_hold_r ? wstrb_r[3] : s_axi_wstrb[3]}},
                    {8{w_hold_r ? wstrb_r[2] : s_axi_wstrb[2]}},
                    {8{w_hold_r ? wstrb_r[1] : s_axi_wstrb[1]}},
                    {8{w_hold_r ? wstrb_r[0] : s_axi_wstrb[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wa[7:2] <= OFS_CLOCK_CTRL[7:2]) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // control registers; start_conv_bit self-clears when taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl0_r <= CTL0_RESET;
            ctl1_r <= CTL1_RESET;
            subsys_off_r <= 1'b0;
            irq_mask_r <= '0;
        end else begin
            if (wr_fire && wa[7:2] == OFS_CONTROL_0[7:2]) begin
                ctl0_r <= (ctl0_r & ~wmask) | (wd & wmask);
            end else if (start_req) begin
                ctl0_r[BIT_START_CONV] <= 1'b0;
            end
            if (wr_fire && wa[7:2] == OFS_CONTROL_1[7:2]) begin
                ctl1_r <= (ctl1_r & ~wmask) | (wd & wmask);
            end
            if (wr_fire && wa[7:2] == OFS_CLOCK_CTRL[7:2] && wmask[0]) begin
                subsys_off_r <= wd[BIT_SUBSYS_OFF];
            end
            if (wr_fire && wa[7:2] == OFS_IRQ_MASK[7:2] && wmask[0]) begin
                irq_mask_r <= wd[IRQ_W-1:0];
            end
        end
    end

    // trigger sources: manual start bit or timer input
    assign start_req = ctl0_r[BIT_START_CONV] || timer_trigger;
    assign overlap = start_req && busy_r && mode != SEQ_SINGLE;
    assign power_toggle = ctl0_r[BIT_POWER_ON] != power_prev_r;
    assign last_chan = chan_r == 2'(CHANNELS - 1);
    assign conv_done = state_r == ST_CONVERT && tick && cnt_r == 6'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_prev_r <= 1'b0;
        end else begin
            power_prev_r <= ctl0_r[BIT_POWER_ON];
        end
    end

    // enable toggle arms the next external trigger
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            armed_r <= 1'b1;
        end else if (!ctl0_r[BIT_CONV_ENABLE]) begin
            armed_r <= 1'b1;
        end else if (state_r == ST_IDLE && start_req) begin
            armed_r <= 1'b0;
        end
    end

    // conversion state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= ST_IDLE;
            cnt_r <= 6'h0;
            chan_r <= 2'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start_req && ctl0_r[BIT_CONV_ENABLE] && ctl0_r[BIT_POWER_ON]
                        && !hung) begin
                        if (timer_trigger && !armed_r) begin
                            state_r <= ST_HALTED;
                        end else begin
                            state_r <= ST_SAMPLE;
                            cnt_r <= {2'h0, ctl0_r[POS_SAMPLE_CLKS +: 4]};
                        end
                    end
                end
                ST_SAMPLE, ST_CONVERT: begin
                    if (overlap || (power_toggle && mode != SEQ_SINGLE)) begin
                        state_r <= ST_HALTED;
                    end else if (tick && cnt_r != 6'h0) begin
                        cnt_r <= cnt_r - 6'h1;
                    end else if (tick && state_r == ST_SAMPLE) begin
                        state_r <= ST_CONVERT;
                        cnt_r <= CONV_CLKS;
                    end else if (conv_done) begin
                        if (mode == SEQ_SINGLE || ((mode == SEQ_SEQUENCE) && last_chan)
                            || !ctl0_r[BIT_CONV_ENABLE]) begin
                            state_r <= ST_IDLE;
                            chan_r <= 2'h0;
                        end else begin
                            state_r <= ST_SAMPLE;
                            cnt_r <= {2'h0, ctl0_r[POS_SAMPLE_CLKS +: 4]};
                            chan_r <= (mode[0] && !last_chan) ? chan_r + 2'h1 : 2'h0;
                        end
                    end
                end
                ST_HALTED: begin
                    if (!ctl0_r[BIT_CONV_ENABLE] && !ctl0_r[BIT_POWER_ON]) begin
                        state_r <= ST_IDLE;
                        chan_r <= 2'h0;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // busy covers the whole conversion or sequence
    assign busy_r = state_r == ST_SAMPLE || state_r == ST_CONVERT;

    // dma pulse after every conversion, also in sequence modes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_r <= 1'b0;
        end else begin
            dma_r <= conv_done && !overlap;
        end
    end

    // result quality flag for short extended sampling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bad_r <= 1'b0;
        end else if (state_r == ST_IDLE && start_req) begin
            bad_r <= !ctl1_r[BIT_PULSE_MODE] && !ctl1_r[POS_REF_SEL]
                     && ctl1_r[POS_REF_SEL +: 4] != 4'h8 && ctl1_r[POS_REF_SEL +: 4] != 4'hA
                     && ctl0_r[POS_SAMPLE_CLKS +: 4] < SAMPLE_MIN_CLKS;
        end
    end

    // interrupt status, set wins over write-one-to-clear
    assign irq_set[IRQ_DONE] = dma_r;
    assign irq_set[IRQ_SEQ_END] = conv_done && (mode == SEQ_SINGLE || last_chan);
    assign irq_set[IRQ_TIMER_OVF] = 1'b0;
    assign irq_set[IRQ_HALT] = state_r != ST_HALTED && (overlap || hung);
    assign irq_clr = (wr_fire && wa[7:2] == OFS_IRQ_STATUS[7:2] && wmask[0]) ?
                     wd[IRQ_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // axi4-lite read
    assign s_axi_arready = !rvalid_r;
    assign ar_fire = s_axi_arvalid && !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            case (s_axi_araddr[7:2])
                OFS_CONTROL_0[7:2]: rdata_r <= ctl0_r;
                OFS_CONTROL_1[7:2]: rdata_r <= ctl1_r;
                OFS_STATUS[7:2]: rdata_r <= {28'h0, bad_r, hung,
                                             state_r == ST_HALTED, busy_r};
                OFS_IRQ_STATUS[7:2]: rdata_r <= {28'h0, irq_stat_r};
                OFS_IRQ_MASK[7:2]: rdata_r <= {28'h0, irq_mask_r};
                OFS_CLOCK_CTRL[7:2]: rdata_r <= {31'h0, subsys_off_r};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign dma_trigger = dma_r;
    assign conv_channel = chan_r;

    // assertions
    sequence seq_overlap_s;
        busy_r && start_req && mode != SEQ_SINGLE;
    endsequence

    AST_OVERLAP_HALTS: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_overlap_s |=> state_r == ST_HALTED)
        else $error("overlapping trigger did not halt");
    AST_NO_TOV_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_overlap_s |=> !irq_stat_r[IRQ_TIMER_OVF])
        else $error("timer overflow flag set on overlap");
    AST_POWER_TOGGLE_HALTS: assert property (@(posedge aclk) disable iff (!aresetn)
        busy_r && power_toggle && mode != SEQ_SINGLE |=> state_r == ST_HALTED)
        else $error("power toggle did not halt");
    AST_UNARMED_TIMER: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_IDLE && timer_trigger && !armed_r && ctl0_r[BIT_CONV_ENABLE]
        && ctl0_r[BIT_POWER_ON] && !hung |=> state_r == ST_HALTED)
        else $error("unarmed timer trigger did not halt");
    AST_DMA_EACH: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && !overlap |=> dma_trigger)
        else $error("dma trigger missing after conversion");
    AST_BUSY_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_SAMPLE && !overlap && !power_toggle |=> busy_r)
        else $error("busy dropped during sampling");
    AST_HANG_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        hung |=> hung && !dma_trigger)
        else $error("hang released without reset");
    AST_BAD_RESULT: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_IDLE && start_req && ctl1_r[BIT_PULSE_MODE] |=> !bad_r)
        else $error("pulse mode flagged bad result");
endmodule : adc_conversion_sequencer
`default_nettype wire

// >>> sim/timer_dma_partner.sv
`timescale 1ns/1ps
`default_nettype none
// timer burst source and single-transfer dma engine
module timer_dma_partner #(
    parameter int SEQ_LEN = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic [3:0] shots,
    input wire logic [9:0] period,
    input wire logic dma_trigger,
    output logic timer_trigger,
    output logic firing,
    output var int dma_count,
    output var int blocks
);
    logic [3:0] left_r;
    logic [9:0] wait_r;
    int xfer_r;
    assign firing = go || (left_r != 4'h0);
    // burst of one-cycle triggers spaced period+1 cycles
    always_ff @(posedge aclk) begin
        timer_trigger <= 1'b0;
        if (!aresetn) begin
            left_r <= 4'h0;
            wait_r <= 10'h000;
        end else if (go) begin
            left_r <= shots;
            wait_r <= 10'h000;
        end else if (left_r != 4'h0 && wait_r != 10'h000) begin
            wait_r <= wait_r - 10'h001;
        end else if (left_r != 4'h0) begin
            timer_trigger <= 1'b1;
            left_r <= left_r - 4'h1;
            wait_r <= period;
        end
    end
    // one transfer per trigger; block done after SEQ_LEN transfers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_count <= 0;
            blocks <= 0;
            xfer_r <= 0;
        end else if (dma_trigger) begin
            dma_count <= dma_count + 1;
            xfer_r <= (xfer_r == SEQ_LEN - 1) ? 0 : xfer_r + 1;
            if (xfer_r == SEQ_LEN - 1) blocks <= blocks + 1;
        end
    end
endmodule : timer_dma_partner
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import conv_seq_pkg::*;
    localparam int CHANNELS = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic go = 1'b0;
    logic [3:0] shots = 4'h0;
    logic [9:0] period = 10'h000;
    logic awready, wready, bvalid, arready, rvalid, timer_trigger, dma_trigger, irq, firing;
    logic [1:0] bresp, rresp, conv_channel;
    logic [31:0] rdata;
    int dma_count, blocks;
    int fails = 0;
    int n_checks = 0;
    int seed = 32'h67A3057F;
    always #20 aclk = ~aclk;
    adc_conversion_sequencer #(.CHANNELS(CHANNELS)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer_trigger(timer_trigger), .dma_trigger(dma_trigger),
        .conv_channel(conv_channel), .irq(irq));
    timer_dma_partner #(.SEQ_LEN(CHANNELS)) partner_u (
        .aclk(aclk), .aresetn(aresetn), .go(go), .shots(shots), .period(period),
        .dma_trigger(dma_trigger), .timer_trigger(timer_trigger), .firing(firing),
        .dma_count(dma_count), .blocks(blocks));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic timeout_hit;
        fails++;
        $display("Error at %0t: wait limit reached", $time);
        complete_run();
    endtask : timeout_hit
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) begin
                bready <= 1'b0;
                return;
            end
        end
        timeout_hit();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic a_t, r_t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            a_t = arvalid && arready;
            r_t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (a_t) arvalid <= 1'b0;
            if (r_t) begin
                rready <= 1'b0;
                return;
            end
        end
        timeout_hit();
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(d & m, e);
    endtask : rdc
    task automatic wait_idle;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 400; i++) begin
            rd(OFS_STATUS, d, r);
            if (d[BIT_BUSY] === 1'b0) return;
        end
        timeout_hit();
    endtask : wait_idle
    task automatic wait_dma(input int n);
        for (int i = 0; i < 3000; i++) begin
            @(negedge aclk);
            if (dma_count >= n) return;
        end
        timeout_hit();
    endtask : wait_dma
    task automatic fire(input logic [3:0] n, input logic [9:0] p);
        @(posedge aclk);
        go <= 1'b1;
        shots <= n;
        period <= p;
        @(posedge aclk);
        go <= 1'b0;
        for (int i = 0; i < 2000; i++) begin
            @(negedge aclk);
            if (!firing) return;
        end
        timeout_hit();
    endtask : fire
    function automatic logic [31:0] c0(input logic [3:0] s, input logic e, input logic p,
        input logic st);
        return {20'h0, s, 3'h0, p, 2'h0, e, st};
    endfunction : c0
    function automatic logic [31:0] c1(input logic [1:0] m, input logic p, input logic [2:0] dv,
        input logic [1:0] src, input logic [3:0] rf);
        return {16'h0, rf, 2'h0, src, 1'b0, dv, 1'b0, p, m};
    endfunction : c1
    function automatic logic bad_exp(input logic p, input logic [3:0] rf, input logic [3:0] s);
        return !p && (rf inside {4'h0, 4'h2, 4'h4, 4'h6, 4'hC, 4'hE}) && (s < 4'h6);
    endfunction : bad_exp
    task automatic arm(input logic [31:0] v, input logic [3:0] s);
        wr(OFS_CONTROL_0, c0(s, 1'b0, 1'b1, 1'b0));
        wr(OFS_CONTROL_1, v);
        wr(OFS_CONTROL_0, c0(s, 1'b1, 1'b1, 1'b0));
    endtask : arm
    task automatic recover(input logic [31:0] v, input logic [3:0] s);
        wr(OFS_CONTROL_0, c0(s, 1'b0, 1'b0, 1'b0));
        arm(v, s);
        wr(OFS_IRQ_STATUS, 32'hF);
    endtask : recover
    initial begin
        repeat (100000) @(posedge aclk);
        timeout_hit();
    end
    initial begin
        logic [31:0] d, sgl;
        logic [1:0] r;
        logic [3:0] sc, s2, rf;
        logic p, hx;
        int n0, b0;
        sgl = c1(SEQ_SINGLE, 1'b1, 3'h0, 2'h0, 4'h0);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(OFS_CONTROL_0, 32'hFFFFFFFF, CTL0_RESET);
        rdc(OFS_CONTROL_1, 32'hFFFFFFFF, CTL1_RESET);
        rdc(OFS_STATUS, 32'hF, 32'h0);
        rd(8'h18, d, r);
        check(d, 32'h0);
        check(r, RESP_SLVERR);
        sc = 4'h6 + 4'({$random(seed)} % 10);
        arm(sgl, sc);
        n0 = dma_count;
        wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b1, 1'b1));
        rdc(OFS_STATUS, 32'h1, 32'h1);
        wait_idle();
        check(dma_count - n0, 1);
        rdc(OFS_IRQ_STATUS, 32'h1, 32'h1);
        @(negedge aclk);
        check(irq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h1);
        @(negedge aclk);
        check(irq, 1'b1);
        wr(OFS_IRQ_STATUS, 32'h1);
        @(negedge aclk);
        check(irq, 1'b0);
        for (int k = 0; k < 2; k++) begin
            arm(c1(k ? SEQ_REPEAT_SEQUENCE : SEQ_SEQUENCE, 1'b1, 3'h0, 2'h0, 4'h0), sc);
            n0 = dma_count;
            b0 = blocks;
            wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b1, 1'b1));
            wait_dma(n0 + 1);
            check(conv_channel, 32'h1);
            rdc(OFS_STATUS, 32'h1, 32'h1);
            if (k == 0) begin
                wait_idle();
                check(dma_count - n0, CHANNELS);
                check(blocks - b0, 32'h1);
            end else begin
                wait_dma(n0 + CHANNELS + 1);
                wr(OFS_CONTROL_0, c0(sc, 1'b0, 1'b1, 1'b0));
                wait_idle();
            end
        end
        for (int m = 1; m < 4; m++) begin
            arm(c1(2'(m), 1'b1, 3'h0, 2'h0, 4'h0), sc);
            wr(OFS_IRQ_STATUS, 32'hF);
            if (m == 1) begin
                fire(4'h2, 10'h00A);
            end else begin
                wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b1, 1'b1));
                wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b1, 1'b1));
            end
            rdc(OFS_STATUS, 32'h2, 32'h2);
            rdc(OFS_IRQ_STATUS, 32'h4, 32'h0);
            recover(sgl, sc);
            wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b1, 1'b1));
            wait_idle();
            rdc(OFS_STATUS, 32'h2, 32'h0);
            rdc(OFS_IRQ_STATUS, 32'h1, 32'h1);
        end
        for (int k = 0; k < 2; k++) begin
            arm(c1(2'(k), 1'b1, 3'h0, 2'h0, 4'h0), sc);
            fire(4'h1, 10'h000);
            wait_idle();
            rdc(OFS_STATUS, 32'h2, 32'h0);
            fire(4'h1, 10'h000);
            rdc(OFS_STATUS, 32'h2, 32'h2);
            recover(sgl, sc);
        end
        fire(4'h1, 10'h000);
        wait_idle();
        arm(sgl, sc);
        fire(4'h1, 10'h000);
        wait_idle();
        rdc(OFS_STATUS, 32'h2, 32'h0);
        for (int m = 1; m < 4; m++) begin
            arm(c1(2'(m), 1'b1, 3'h0, 2'h0, 4'h0), sc);
            wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b1, 1'b1));
            wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b0, 1'b0));
            wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b1, 1'b0));
            rdc(OFS_STATUS, 32'h2, 32'h2);
            recover(c1(2'(m), 1'b1, 3'h0, 2'h0, 4'h0), sc);
            wr(OFS_CONTROL_0, c0(sc, 1'b1, 1'b1, 1'b1));
            wr(OFS_CONTROL_0, c0(sc, 1'b0, 1'b1, 1'b0));
            wait_idle();
            wr(OFS_CONTROL_0, c0(sc, 1'b0, 1'b0, 1'b0));
            wr(OFS_CONTROL_0, c0(sc, 1'b0, 1'b1, 1'b0));
            rdc(OFS_STATUS, 32'h2, 32'h0);
        end
        for (int i = 0; i < 24; i++) begin
            rf = (i < 16) ? 4'(i) : 4'($random(seed));
            s2 = (i < 16) ? 4'h5 : 4'h4 + 4'({$random(seed)} % 4);
            p = (i >= 16) && ({$random(seed)} % 3 == 0);
            arm(c1(SEQ_SINGLE, p, 3'h0, 2'h0, rf), s2);
            wr(OFS_CONTROL_0, c0(s2, 1'b1, 1'b1, 1'b1));
            wait_idle();
            rdc(OFS_STATUS, 32'h8, bad_exp(p, rf, s2) ? 32'h8 : 32'h0);
        end
        wr(OFS_CONTROL_0, 32'h0);
        for (int i = 0; i < 16; i++) begin
            hx = (i >= 8) && ((i % 8) inside {2, 4, 6});
            wr(OFS_CLOCK_CTRL, (i >= 8) ? 32'h1 : 32'h0);
            wr(OFS_CONTROL_1, c1(SEQ_SINGLE, 1'b1, 3'(i), CLK_SRC_SUBSYS, 4'h0));
            wr(OFS_CONTROL_1, c1(SEQ_SINGLE, 1'b1, 3'(i), 2'h0, 4'h0));
            rdc(OFS_STATUS, 32'h4, hx ? 32'h4 : 32'h0);
            if (hx) begin
                @(posedge aclk);
                aresetn <= 1'b0;
                repeat (5) @(posedge aclk);
                aresetn <= 1'b1;
                rdc(OFS_STATUS, 32'h4, 32'h0);
            end
        end
        complete_run();
    end
endmodule : tb
`default_nettype wire
